// file: inc/pmcu_pkg.sv
// Purpose: constants and carrier types for the paging character unpacker
// Assumes: code words arrive already corrected, 21 information bits each
// Notes:   message types are tagged by the upstream decoder
//
// Notes on behaviour
// - First fragment text starts at word2 char2
// - ETX code 03 is fill, not text
// - Trailing nulls are fill, removed from output
// - Non-trailing null flags a channel error
// - Full last word ends message without ETX
// - Start-mode bits read only after first fragment
// - First fragment starts in default mode
// - Decode start-mode: 00 none, 01 reserved
// - Mode 00 joins characters split across fragments
// - Nonzero mode: fragment starts on boundary
// - Secure header: sum, more, piece, sequence, spare
// - Secure chars at i0, i7, i14, LSB first
// - Reassemble secure fragments across transmissions
// - Check ones complement ten-bit group sum
// - Piece index modulo-3, 11 only at start
// - Cleared more-pending flag marks final fragment
package pmcu_pkg;
    localparam int unsigned INFO_W      = 21;
    localparam int unsigned CHAR_W      = 7;
    localparam int unsigned SUM_W       = 10;
    localparam logic [6:0]  CH_ETX      = 7'h03;
    localparam logic [6:0]  CH_NUL      = 7'h00;
    // Secure header field positions
    localparam int unsigned SUM_LSB     = 0;
    localparam int unsigned MORE_BIT    = 10;
    localparam int unsigned PIECE_LSB   = 11;
    localparam int unsigned SEQ_LSB     = 13;
    localparam int unsigned SPARE_LSB   = 19;
    localparam int unsigned G1_LSB      = 8;
    localparam int unsigned G2_LSB      = 16;
    localparam logic [1:0]  PIECE_START = 2'h3;
    localparam logic [1:0]  MODE_NONE   = 2'h0;
    localparam logic [1:0]  MODE_RSVD   = 2'h1;
    localparam logic [1:0]  MODE_DFLT   = 2'h2;
    localparam logic [1:0]  MODE_ALT    = 2'h3;

    typedef enum logic [1:0] {PMCU_ALPHA, PMCU_SECURE, PMCU_OTHER} pmcu_kind_e;

    typedef struct packed {
        logic [20:0] info;     // information bits i20..i0
        logic        first;    // first word of fragment
        logic        last;     // last word of fragment
        logic        frag0;    // fragment is the initial one
        logic [1:0]  mode;     // start-mode pair hi,lo
        pmcu_kind_e  kind;
    } pmcu_word_s;

    typedef struct packed {
        logic [6:0] ch;
        logic       alt;       // alternate character mode
        logic       split;     // piece of a character split across fragments
        logic       eom;       // character from last word of fragment
    } pmcu_char_s;

    typedef struct packed {
        logic [9:0] sum;
        logic       more;
        logic [1:0] piece;
        logic [5:0] seq;
        logic [1:0] spare;
    } pmcu_shdr_s;
endpackage

// file: src/pmcu_char_slot.sv
// Purpose: classify one 7-bit slot of a code word
// Assumes: slot bits are LSB first
// Notes:   used three times per word
`timescale 1ns/100ps
module pmcu_char_slot import pmcu_pkg::*; (
    input  wire logic [6:0] ch,        // slot character
    output logic            is_fill,   // ETX or NUL
    output logic            is_nul     // NUL only
);
    assign is_nul  = (ch == CH_NUL);
    assign is_fill = is_nul || (ch == CH_ETX);
endmodule

// file: src/pmcu_unpacker.sv
// Purpose: unpack paging message words into characters
// Assumes: one word per cycle at most, word_vld from same clock
// Notes:   character output is one character per word slot, up to three per word
`timescale 1ns/100ps
module pmcu_unpacker import pmcu_pkg::*; (
    input  wire logic       clk,        // 200 MHz clock
    input  wire logic       rst_n,      // sync reset, active low
    input  wire pmcu_word_s word_in,    // incoming code word
    input  wire logic       word_vld,   // word strobe
    output pmcu_char_s      char_out,   // character carrier
    output logic [2:0]      char_vld,   // slot valid mask, slot0 = bit0
    output logic [20:0]     char_bus,   // three characters, slot0 low
    output pmcu_shdr_s      shdr_out,   // secure header fields
    output logic            shdr_vld,   // header strobe
    output logic            frag_done,  // fragment end pulse
    output logic            msg_done,   // message end pulse
    output logic            err_flag,   // checksum or null fault pulse
    output logic            mode_rsvd   // last start-mode was reserved
);
    // ------------------------------------------------------------
    // Slot split and fill detection
    // ------------------------------------------------------------
    logic [6:0] slot [3];
    logic [2:0] fill;
    logic [2:0] nul;
    genvar g;
    for (g = 0; g < 3; g++) begin : g_slot
        assign slot[g] = word_in.info[g*CHAR_W +: CHAR_W];
        pmcu_char_slot u_slot (
            .ch      (slot[g]),
            .is_fill (fill[g]),
            .is_nul  (nul[g])
        );
    end

    // ------------------------------------------------------------
    // Fragment tracking
    // ------------------------------------------------------------
    logic       word2_ff;     // next word is second word
    logic       seen_fill_ff; // null seen, rest must be fill
    logic [9:0] sum_ff;
    logic [9:0] rx_sum_ff;
    logic       more_ff;
    logic [1:0] piece_ff;
    logic       piece_ok_ff;
    logic       alt_ff;
    logic       split_ok_ff;

    wire logic hdr = word_vld && word_in.first;
    wire logic [1:0] split_rule_sel = word_in.frag0 ? MODE_DFLT : word_in.mode;
    // Check field counts as zero while summing, as the sender computes it
    wire logic [20:0] sum_src = (hdr && word_in.kind == PMCU_SECURE)
                              ? {word_in.info[INFO_W-1:SUM_LSB+SUM_W], {SUM_W{1'b0}}}
                              : word_in.info;
    wire logic [9:0] grp_sum = 10'(sum_src[G1_LSB-1:0])
                             + 10'(sum_src[G2_LSB-1:G1_LSB])
                             + 10'(sum_src[INFO_W-1:G2_LSB]);
    wire logic [9:0] sum_nxt = (hdr ? 10'h000 : sum_ff) + grp_sum;
    wire logic [9:0] rx_sum  = hdr ? word_in.info[SUM_LSB +: SUM_W] : rx_sum_ff;
    wire logic       sum_bad = word_vld && word_in.last && word_in.kind == PMCU_SECURE
                             && (~sum_nxt != rx_sum);

    // Null that is followed by text in same fragment is a channel error
    logic [2:0] keep;
    logic       nul_bad;
    logic       fill_any;
    always_comb begin
        keep     = 3'h0;
        nul_bad  = 1'b0;
        fill_any = seen_fill_ff;
        for (int k = 0; k < 3; k++) begin
            if (fill[k]) begin
                if (nul[k]) begin
                    fill_any = 1'b1;
                end
            end else begin
                keep[k] = 1'b1;
                if (fill_any) begin
                    nul_bad = 1'b1;
                end
            end
        end
        if (word_in.first || word_in.kind == PMCU_OTHER) begin
            keep    = 3'h0;
            nul_bad = 1'b0;
        end else if (word2_ff && word_in.frag0 && word_in.kind == PMCU_ALPHA) begin
            keep[0] = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word2_ff     <= 1'b0;
            seen_fill_ff <= 1'b0;
        end else if (word_vld) begin
            word2_ff     <= word_in.first;
            seen_fill_ff <= word_in.last ? 1'b0 : (word_in.first ? 1'b0 : fill_any);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sum_ff    <= 10'h000;
            rx_sum_ff <= 10'h000;
        end else if (word_vld) begin
            sum_ff    <= sum_nxt;
            rx_sum_ff <= rx_sum;
        end
    end

    // Secure header and piece order, reassembled across transmissions
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            more_ff     <= 1'b0;
            piece_ff    <= PIECE_START;
            piece_ok_ff <= 1'b1;
        end else if (hdr && word_in.kind == PMCU_SECURE) begin
            more_ff  <= word_in.info[MORE_BIT];
            piece_ff <= word_in.info[PIECE_LSB +: 2];
            if (word_in.info[PIECE_LSB +: 2] == PIECE_START) begin
                piece_ok_ff <= 1'b1;
            end else begin
                piece_ok_ff <= more_ff && word_in.info[PIECE_LSB +: 2]
                               == ((piece_ff == 2'h2) ? 2'h0 : 2'(piece_ff + 2'h1));
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alt_ff      <= 1'b0;
            split_ok_ff <= 1'b0;
            mode_rsvd   <= 1'b0;
        end else if (hdr && word_in.kind == PMCU_ALPHA) begin
            unique case (split_rule_sel)
                MODE_NONE: begin
                    split_ok_ff <= 1'b1;
                    mode_rsvd   <= 1'b0;
                end
                MODE_RSVD: begin
                    split_ok_ff <= 1'b0;
                    mode_rsvd   <= 1'b1;
                end
                MODE_DFLT: begin
                    alt_ff      <= 1'b0;
                    split_ok_ff <= 1'b0;
                    mode_rsvd   <= 1'b0;
                end
                MODE_ALT: begin
                    alt_ff      <= 1'b1;
                    split_ok_ff <= 1'b0;
                    mode_rsvd   <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            char_vld <= 3'h0;
            char_bus <= 21'h000000;
            char_out <= '0;
        end else begin
            char_vld <= word_vld ? keep : 3'h0;
            if (word_vld) begin
                char_bus    <= word_in.info;
                char_out.ch <= slot[0];
            end
            char_out.alt   <= alt_ff;
            // First text word of a mode 00 fragment may carry a character piece
            char_out.split <= split_ok_ff && word2_ff && word_vld && word_in.kind == PMCU_ALPHA;
            char_out.eom   <= word_vld && word_in.last;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shdr_out <= '0;
            shdr_vld <= 1'b0;
        end else begin
            shdr_vld <= hdr && word_in.kind == PMCU_SECURE;
            if (hdr && word_in.kind == PMCU_SECURE) begin
                shdr_out.sum   <= word_in.info[SUM_LSB +: SUM_W];
                shdr_out.more  <= word_in.info[MORE_BIT];
                shdr_out.piece <= word_in.info[PIECE_LSB +: 2];
                shdr_out.seq   <= word_in.info[SEQ_LSB +: 6];
                shdr_out.spare <= word_in.info[SPARE_LSB +: 2];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frag_done <= 1'b0;
            msg_done  <= 1'b0;
            err_flag  <= 1'b0;
        end else begin
            frag_done <= word_vld && word_in.last;
            msg_done  <= word_vld && word_in.last && (word_in.kind != PMCU_SECURE || !more_ff);
            err_flag  <= (word_vld && nul_bad && word_in.kind != PMCU_OTHER) || sum_bad;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_etx_not_text: assert property (@(posedge clk) disable iff (!rst_n)
        word_vld && !word_in.first && slot[1] == CH_ETX |=> !char_vld[1])
        else $error("ETX slot passed as text");
    a_first_skip: assert property (@(posedge clk) disable iff (!rst_n)
        word_vld && word2_ff && word_in.frag0 && word_in.kind == PMCU_ALPHA |=> !char_vld[0])
        else $error("first fragment char not skipped");
    a_nul_removed: assert property (@(posedge clk) disable iff (!rst_n)
        word_vld && word_in.last && slot[2] == CH_NUL |=> !char_vld[2])
        else $error("trailing null reached output");
    a_nul_error: assert property (@(posedge clk) disable iff (!rst_n)
        word_vld && !word_in.first && word_in.kind == PMCU_ALPHA && nul[0] && !fill[2] |=> err_flag)
        else $error("misplaced null not flagged");
    a_hdr_fields: assert property (@(posedge clk) disable iff (!rst_n)
        hdr && word_in.kind == PMCU_SECURE |=> shdr_vld && shdr_out.piece == $past(word_in.info[12:11]))
        else $error("secure header misparsed");
    a_sum_check: assert property (@(posedge clk) disable iff (!rst_n)
        sum_bad |=> err_flag)
        else $error("checksum fault not flagged");
    a_first_mode: assert property (@(posedge clk) disable iff (!rst_n)
        hdr && word_in.kind == PMCU_ALPHA && word_in.frag0 |=> !alt_ff && !split_ok_ff)
        else $error("first fragment not default mode");
    a_alt_mode: assert property (@(posedge clk) disable iff (!rst_n)
        hdr && word_in.kind == PMCU_ALPHA && !word_in.frag0 && word_in.mode == MODE_ALT |=> alt_ff)
        else $error("alternate mode not taken");
    a_piece_order: assert property (@(posedge clk) disable iff (!rst_n)
        hdr && word_in.kind == PMCU_SECURE && more_ff && piece_ff == PIECE_START
        && word_in.info[PIECE_LSB +: 2] == 2'h0 |=> piece_ok_ff)
        else $error("piece order not accepted");
    a_msg_end: assert property (@(posedge clk) disable iff (!rst_n)
        word_vld && word_in.last && word_in.kind == PMCU_ALPHA |=> msg_done && frag_done)
        else $error("message end missed");
endmodule

// file: tb/pmcu_src_model.sv
// Purpose: channel decoder stand-in feeding corrected code words
// Assumes: bench gives raw words; model pads the last word
// Notes:   info lines show inverted data while no word is offered
`timescale 1ns/100ps
module pmcu_src_model import pmcu_pkg::*; (
    input  wire pmcu_word_s raw,       // word from bench
    input  wire logic       go,        // word offered
    input  wire logic [1:0] fill_cnt,  // trailing slots to pad
    input  wire logic       fill_nul,  // pad with NUL, else ETX
    output pmcu_word_s      word_in,   // to unpacker
    output logic            word_vld   // to unpacker
);
    always_comb begin
        word_in  = raw;
        word_vld = go;
        for (int k = 0; k < 3; k++) begin
            if (raw.last && (int'(fill_cnt) + k >= 3)) begin
                word_in.info[7*k+:7] = fill_nul ? CH_NUL : CH_ETX;
            end
        end
        // No stale data between words
        if (!go) begin
            word_in.info = ~raw.info;
        end
    end
endmodule

// file: tb/pmcu_unpacker_tb_top.sv
// Purpose: self-checking bench of the character unpacker
// Assumes: one word per cycle, answer read 1 ns after the taking edge
// Notes:   random text never uses fill codes, so fill is only placed on purpose
`timescale 1ns/100ps
module pmcu_unpacker_tb_top;
    import pmcu_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, go = 1'b0, fill_nul = 1'b0;
    logic [1:0]  fill_cnt = 2'h0;
    pmcu_word_s  raw = '0, word_in;
    pmcu_char_s  char_out;
    pmcu_shdr_s  shdr_out, hx;
    logic [2:0]  char_vld, em;
    logic [20:0] char_bus, w [3];
    logic        word_vld, shdr_vld, frag_done, msg_done, err_flag, mode_rsvd, fr0, more;
    logic [9:0]  acc;
    int          miscompares = 0, samples_checked = 0, cyc = 0, n;
    pmcu_src_model u_pmcu_src_model (.raw(raw), .go(go), .fill_cnt(fill_cnt), .fill_nul(fill_nul),
        .word_in(word_in), .word_vld(word_vld));
    pmcu_unpacker u_pmcu_unpacker (.clk(clk), .rst_n(rst_n), .word_in(word_in), .word_vld(word_vld),
        .char_out(char_out), .char_vld(char_vld), .char_bus(char_bus), .shdr_out(shdr_out),
        .shdr_vld(shdr_vld), .frag_done(frag_done), .msg_done(msg_done), .err_flag(err_flag),
        .mode_rsvd(mode_rsvd));
    // ---------------------------------------
    // Helpers
    // ---------------------------------------
    function automatic logic [20:0] txt3();
        return {7'h20 + 7'($urandom % 95), 7'h20 + 7'($urandom % 95), 7'h20 + 7'($urandom % 95)};
    endfunction
    function automatic logic [9:0] gsum(input logic [20:0] i);
        return 10'(i[7:0]) + 10'(i[15:8]) + 10'(i[20:16]);
    endfunction
    function automatic logic [20:0] hword(input pmcu_shdr_s h);
        return {h.spare, h.seq, h.piece, h.more, h.sum};
    endfunction
    task automatic test_done();
        if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [20:0] i, input logic f, l, f0, input logic [1:0] m, input pmcu_kind_e k);
        raw = '{i, f, l, f0, m, k};
        go  = 1'b1;
        @(posedge clk);
        #1;
    endtask
    task automatic idle(input int c);
        go = 1'b0;
        repeat (c) @(posedge clk);
        #1;
    endtask
    // ---------------------------------------
    // Clock, timeout, sequence
    // ---------------------------------------
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32'h7178));
        repeat (6) @(posedge clk);
        #1;
        rst_n = 1'b1;
        cmp({shdr_vld, msg_done, err_flag, mode_rsvd, char_vld}, 21'h0);
        // Secure fragments in separate bursts; piece runs 11, 00, 01
        for (int f = 0; f < 3; f++) begin
            n = 2 + $urandom % 2;
            more = (f < 2);
            hx = '{10'h0, more, (f == 0) ? PIECE_START : 2'(f - 1), 6'($urandom), 2'h0};
            acc = gsum(hword(hx));
            for (int j = 0; j < n; j++) begin
                w[j] = txt3();
                acc += gsum(w[j]);
            end
            hx.sum = ~acc ^ ((f == 1) ? 10'h001 : 10'h000);
            send(hword(hx), 1'b1, 1'b0, f == 0, 2'h0, PMCU_SECURE);
            cmp({shdr_vld, shdr_out}, {1'b1, hx});
            for (int j = 0; j < n; j++) begin
                send(w[j], 1'b0, j == n - 1, f == 0, 2'h0, PMCU_SECURE);
                cmp(char_bus, w[j]);
            end
            cmp({frag_done, msg_done}, {1'b1, !more});
            cmp(err_flag, f == 1);
            idle(4);
        end
        // Alpha: initial fragment, then modes 00, 01, 10, 11
        for (int m = 0; m < 5; m++) begin
            fr0 = (m == 0);
            send(21'h0, 1'b1, 1'b0, fr0, 2'(m + 3), PMCU_ALPHA);
            cmp(mode_rsvd, !fr0 && m == 2);
            send(txt3(), 1'b0, 1'b0, fr0, 2'(m + 3), PMCU_ALPHA);
            cmp(char_vld, fr0 ? 3'h6 : 3'h7);
            cmp(char_out.alt, !fr0 && m == 4);
            cmp(char_out.split, !fr0 && m == 1);
            fill_cnt = 2'(m % 3);
            fill_nul = m[0];
            em = 3'h7 >> fill_cnt;
            w[0] = txt3();
            send(w[0], 1'b0, 1'b1, fr0, 2'(m + 3), PMCU_ALPHA);
            cmp(char_vld, em);
            cmp({char_out.eom, char_out.ch}, {1'b1, w[0][6:0]});
            cmp({err_flag, frag_done, msg_done}, 3'h3);
            fill_cnt = 2'h0;
            idle(2);
        end
        // Null inside text is a channel error; other-kind words give no characters
        send(21'h0, 1'b1, 1'b0, 1'b0, MODE_DFLT, PMCU_ALPHA);
        send(txt3() & 21'h1FFF80, 1'b0, 1'b1, 1'b0, MODE_DFLT, PMCU_ALPHA);
        cmp(err_flag, 1'b1);
        idle(1);
        send(txt3(), 1'b0, 1'b1, 1'b0, MODE_DFLT, PMCU_OTHER);
        cmp(char_vld, 3'h0);
        idle(2);
        test_done();
    end
endmodule
